// [sim/pci_pin_model.sv]
// model of the outside circuit that drives the port pins
`timescale 1ns/100ps
module pci_pin_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] pin_level,
    output logic      [7:0] second_port_pins
);
    // pins follow the requested level one clock later
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            second_port_pins <= 8'h00;
        else
            second_port_pins <= pin_level;
    end
endmodule : pci_pin_model

// [sim/tb.sv]
// self-checking bench for the pin change interrupt block
`timescale 1ns/100ps
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        change_irq, wake_req, irq, err;
    logic [7:0]  paddr, pin_level, pins;
    logic [31:0] pwdata, prdata, v;
    int          n_errors, checked, cycles, n;

    pci_pin_model u_pins (.pclk(pclk), .presetn(presetn), .pin_level(pin_level), .second_port_pins(pins));
    pci_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .second_port_pins(pins), .change_irq(change_irq), .wake_req(wake_req), .irq(irq));

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic finish_test;
        if (n_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, waits for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
            n_errors++;
        v = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(v, exp);
    endtask : rd

    task automatic settle;
        repeat (5) @(posedge pclk);
    endtask : settle

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            finish_test();
        end
    end

    initial
    begin
        n_errors = 0;
        checked = 0;
        cycles = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pin_level = 8'h00;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
        rd(8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, pci_pkg::ADDR_RISE_EN, 32'h0f);
        apb(1'b1, pci_pkg::ADDR_FALL_EN, 32'h3c);
        rd(pci_pkg::ADDR_RISE_EN, 32'h0f);
        rd(pci_pkg::ADDR_FALL_EN, 32'h3c);
        pin_level <= 8'hff;
        settle();
        rd(pci_pkg::ADDR_FLAGS, 32'h0f);
        chk({31'h0, change_irq}, 32'h0);
        rd(pci_pkg::ADDR_CONTROL, 32'h04);
        pin_level <= 8'h00;
        settle();
        rd(pci_pkg::ADDR_FLAGS, 32'h3f);
        // write zero to every flag bit, clearing all eight flags
        rd(pci_pkg::ADDR_FLAGS, 32'h3f);
        apb(1'b1, pci_pkg::ADDR_FLAGS, (v ^ 32'hff) & v);
        rd(pci_pkg::ADDR_FLAGS, 32'h0);
        rd(pci_pkg::ADDR_CONTROL, 32'h0);
        apb(1'b1, pci_pkg::ADDR_IRQ_MASK, 32'h01);
        rd(pci_pkg::ADDR_IRQ_STAT, 32'h0);
        apb(1'b1, pci_pkg::ADDR_IRQ_STAT, 32'h03);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, pci_pkg::ADDR_CONTROL, 32'h01);
        pin_level <= 8'h01;
        settle();
        chk({31'h0, change_irq}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, pci_pkg::ADDR_IRQ_STAT, 32'h01);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        // edge on pin 2 lands during the flag write
        pin_level <= 8'h05;
        @(posedge pclk);
        apb(1'b1, pci_pkg::ADDR_FLAGS, 32'h0);
        settle();
        rd(pci_pkg::ADDR_FLAGS, 32'h04);
        apb(1'b1, pci_pkg::ADDR_FLAGS, 32'h0);
        apb(1'b1, pci_pkg::ADDR_CONTROL, 32'h03);
        pin_level <= 8'h07;
        n = 0;
        while (wake_req !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, wake_req}, 32'h1);
        rd(pci_pkg::ADDR_FLAGS, 32'h02);
        rd(pci_pkg::ADDR_CONTROL, 32'h05);
        rd(pci_pkg::ADDR_IRQ_STAT, 32'h03);
        rd(pci_pkg::ADDR_IRQ_MASK, 32'h01);
        chk({31'h0, irq}, 32'h1);
        finish_test();
    end
endmodule : tb

// [src/pci_pkg.sv]
// package for the pin change interrupt block
package pci_pkg;

    localparam int unsigned PIN_COUNT = 8;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RISE_EN  = 8'h00;
    localparam logic [7:0] ADDR_FALL_EN  = 8'h04;
    localparam logic [7:0] ADDR_FLAGS    = 8'h08;
    localparam logic [7:0] ADDR_CONTROL  = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned CTRL_MASTER_EN_BIT = 0;
    localparam int unsigned CTRL_SLEEP_BIT     = 1;
    localparam int unsigned CTRL_SUMMARY_BIT   = 2;
    localparam int unsigned STAT_EDGE_BIT      = 0;
    localparam int unsigned STAT_WAKE_BIT      = 1;
    localparam int unsigned STAT_WIDTH         = 2;

    localparam logic [7:0]  RESET_BYTE  = 8'h00;
    localparam logic [1:0]  RESET_STAT  = 2'h0;
    localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

    // pin samples travel together
    typedef struct packed {
        logic [PIN_COUNT-1:0] cur;
        logic [PIN_COUNT-1:0] prev;
    } pci_sample_t;

endpackage : pci_pkg

// [src/pci_top.sv]
// pin change interrupt block with apb register slave
`timescale 1ns/100ps

// Notes on behaviour
// R01: any pin or combination of pins may be a change interrupt source.
// R02: interrupt only with master enable set; detection and flags continue regardless.
// R03: per-pin rising-edge detector active when its rise enable bit is set.
// R04: per-pin falling-edge detector active when its fall enable bit is set.
// R05: both enables set means either edge direction is detected and flagged.
// R06: enabled edge sets the pin flag, and interrupts if master enable set.
// R07: summary flag is the OR of all eight pin flags.
// R08: writing zero to a pin flag clears it.
// R09: an edge during a flag write leaves that flag set, whatever is written.
// R10: software should clear flags by AND masking only bits known set.
// R11: with master enable set, a detected enabled edge wakes from sleep.
// R12: an edge during sleep is in the flags in the same cycle that wake is signalled.
// R13: flags set on enabled rising or falling edge; flags reset to zero.
// R14: pins synchronised to clock; edges from current versus previous sample.
module pci_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  second_port_pins,
    output logic             change_irq,
    output logic             wake_req,
    output logic             irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  sync1_q, sync1_d;
    pci_pkg::pci_sample_t smp_q, smp_d;
    logic [2:0]  primed_q, primed_d;
    logic [7:0]  rise_edge_enable_q, rise_edge_enable_d;
    logic [7:0]  fall_edge_enable_q, fall_edge_enable_d;
    logic [7:0]  pin_change_flags_q, pin_change_flags_d;
    logic        change_irq_master_enable_q, change_irq_master_enable_d;
    logic        sleep_q, sleep_d;
    logic [1:0]  stat_q, stat_d;
    logic [1:0]  mask_q, mask_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        change_irq_q, change_irq_d;
    logic        wake_q, wake_d;
    logic        irq_q, irq_d;

    logic [7:0]  rise_seen;
    logic [7:0]  fall_seen;
    logic [7:0]  hit;
    logic        access;
    logic        wr;
    logic        mapped;
    logic        any_hit;

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < pci_pkg::PIN_COUNT; g++)
        begin : g_pin
            // R14: compare current with previous sample
            assign rise_seen[g] = primed_q[2] & smp_q.cur[g] & ~smp_q.prev[g];
            assign fall_seen[g] = primed_q[2] & ~smp_q.cur[g] & smp_q.prev[g];
            // R03: rising detector gated by its enable
            // R04: falling detector gated by its enable
            // R05: either direction when both set
            // R01: each pin an independent source
            assign hit[g] = (rise_seen[g] & rise_edge_enable_q[g]) | (fall_seen[g] & fall_edge_enable_q[g]);
        end
    endgenerate

    assign any_hit = |hit;
    assign access  = psel & penable & ~pready_q;
    assign wr      = access & pwrite;

    always_comb
    begin
        sync1_d    = second_port_pins;
        smp_d.cur  = sync1_q;
        smp_d.prev = smp_q.cur;
        // detection waits until prev holds a real pin sample
        primed_d   = {primed_q[1:0], 1'b1};
    end

    // ------------------------------------------------------------
    // registers and flags
    // ------------------------------------------------------------
    always_comb
    begin
        rise_edge_enable_d         = rise_edge_enable_q;
        fall_edge_enable_d         = fall_edge_enable_q;
        pin_change_flags_d         = pin_change_flags_q;
        change_irq_master_enable_d = change_irq_master_enable_q;
        sleep_d                    = sleep_q;
        mask_d                     = mask_q;
        stat_d                     = stat_q;
        if (wr)
        begin
            case (paddr)
                pci_pkg::ADDR_RISE_EN:  rise_edge_enable_d = pwdata[7:0];
                pci_pkg::ADDR_FALL_EN:  fall_edge_enable_d = pwdata[7:0];
                // R08: written zeros clear flags
                pci_pkg::ADDR_FLAGS:    pin_change_flags_d = pwdata[7:0];
                pci_pkg::ADDR_CONTROL:
                begin
                    change_irq_master_enable_d = pwdata[pci_pkg::CTRL_MASTER_EN_BIT];
                    sleep_d                    = pwdata[pci_pkg::CTRL_SLEEP_BIT];
                end
                pci_pkg::ADDR_IRQ_STAT: stat_d = stat_q & ~pwdata[pci_pkg::STAT_WIDTH-1:0];
                pci_pkg::ADDR_IRQ_MASK: mask_d = pwdata[pci_pkg::STAT_WIDTH-1:0];
                default:                stat_d = stat_q;
            endcase
        end
        // R09: a coincident edge wins over the write
        // R13: hardware sets flags on enabled edges
        // R02: flags set even with master enable clear
        pin_change_flags_d = pin_change_flags_d | hit;
        // R11: wake from sleep only with master enable
        if (sleep_q && any_hit && change_irq_master_enable_q)
        begin
            sleep_d = 1'b0;
        end
        // R02: edge status only with master enable
        if (any_hit && change_irq_master_enable_q)
        begin
            stat_d[pci_pkg::STAT_EDGE_BIT] = 1'b1;
        end
        if (sleep_q && any_hit && change_irq_master_enable_q)
        begin
            stat_d[pci_pkg::STAT_WAKE_BIT] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // outputs and apb answer
    // ------------------------------------------------------------
    always_comb
    begin
        mapped = 1'b1;
        prdata_d = pci_pkg::RDATA_ZERO;
        case (paddr)
            pci_pkg::ADDR_RISE_EN:  prdata_d[7:0] = rise_edge_enable_q;
            pci_pkg::ADDR_FALL_EN:  prdata_d[7:0] = fall_edge_enable_q;
            pci_pkg::ADDR_FLAGS:    prdata_d[7:0] = pin_change_flags_q;
            pci_pkg::ADDR_CONTROL:
            begin
                prdata_d[pci_pkg::CTRL_MASTER_EN_BIT] = change_irq_master_enable_q;
                prdata_d[pci_pkg::CTRL_SLEEP_BIT]     = sleep_q;
                prdata_d[pci_pkg::CTRL_SUMMARY_BIT]   = |pin_change_flags_q;
            end
            pci_pkg::ADDR_IRQ_STAT: prdata_d[pci_pkg::STAT_WIDTH-1:0] = stat_q;
            pci_pkg::ADDR_IRQ_MASK: prdata_d[pci_pkg::STAT_WIDTH-1:0] = mask_q;
            default:                mapped = 1'b0;
        endcase
        if (!access)
        begin
            prdata_d = prdata_q;
        end
        pready_d  = access;
        pslverr_d = access & ~mapped;
        // R07: summary follows the OR of the flags
        // R06: interrupt raised only with master enable
        change_irq_d = change_irq_master_enable_q & (|pin_change_flags_d);
        // R12: wake raised together with the flag update
        wake_d = sleep_q & change_irq_master_enable_q & any_hit;
        irq_d  = |(stat_d & mask_q);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q                    <= pci_pkg::RESET_BYTE;
            smp_q                      <= '0;
            primed_q                   <= '0;
            rise_edge_enable_q         <= pci_pkg::RESET_BYTE;
            fall_edge_enable_q         <= pci_pkg::RESET_BYTE;
            pin_change_flags_q         <= pci_pkg::RESET_BYTE;
            change_irq_master_enable_q <= 1'b0;
            sleep_q                    <= 1'b0;
            stat_q                     <= pci_pkg::RESET_STAT;
            mask_q                     <= pci_pkg::RESET_STAT;
            prdata_q                   <= pci_pkg::RDATA_ZERO;
            pready_q                   <= 1'b0;
            pslverr_q                  <= 1'b0;
            change_irq_q               <= 1'b0;
            wake_q                     <= 1'b0;
            irq_q                      <= 1'b0;
        end
        else
        begin
            sync1_q                    <= sync1_d;
            smp_q                      <= smp_d;
            primed_q                   <= primed_d;
            rise_edge_enable_q         <= rise_edge_enable_d;
            fall_edge_enable_q         <= fall_edge_enable_d;
            pin_change_flags_q         <= pin_change_flags_d;
            change_irq_master_enable_q <= change_irq_master_enable_d;
            sleep_q                    <= sleep_d;
            stat_q                     <= stat_d;
            mask_q                     <= mask_d;
            prdata_q                   <= prdata_d;
            pready_q                   <= pready_d;
            pslverr_q                  <= pslverr_d;
            change_irq_q               <= change_irq_d;
            wake_q                     <= wake_d;
            irq_q                      <= irq_d;
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign change_irq = change_irq_q;
    assign wake_req   = wake_q;
    assign irq        = irq_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_rise_sets_flag: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (rise_seen[0] & rise_edge_enable_q[0]) |=> pin_change_flags_q[0])
        else $error("rising edge did not set flag");
    a_fall_sets_flag: assert property (@(posedge pclk) disable iff (!presetn) // R04
        (fall_seen[0] & fall_edge_enable_q[0]) |=> pin_change_flags_q[0])
        else $error("falling edge did not set flag");
    a_no_edge_no_set: assert property (@(posedge pclk) disable iff (!presetn) // R13
        (!pin_change_flags_q[0] && !hit[0] && !(wr && paddr == pci_pkg::ADDR_FLAGS)) |=> !pin_change_flags_q[0])
        else $error("flag set without enabled edge");
    a_edge_beats_wr: assert property (@(posedge pclk) disable iff (!presetn) // R09
        (wr && paddr == pci_pkg::ADDR_FLAGS && hit != 8'h00) |=> ((pin_change_flags_q & $past(hit)) == $past(hit)))
        else $error("edge lost during flag write");
    a_zero_clears: assert property (@(posedge pclk) disable iff (!presetn) // R08
        (wr && paddr == pci_pkg::ADDR_FLAGS && hit == 8'h00) |=> pin_change_flags_q == $past(pwdata[7:0]))
        else $error("flag write not applied");
    a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn) // R02
        change_irq |-> ($past(change_irq_master_enable_q) && pin_change_flags_q != 8'h00))
        else $error("change irq without master enable");
    a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn) // R06
        (change_irq_master_enable_q && hit != 8'h00) |=> change_irq)
        else $error("change irq missing");
    a_wake_edge: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (sleep_q && change_irq_master_enable_q && any_hit) |=> (wake_req && !sleep_q))
        else $error("no wake on edge");
    a_wake_flags: assert property (@(posedge pclk) disable iff (!presetn) // R12
        wake_req |-> pin_change_flags_q != 8'h00)
        else $error("wake before flags recorded");
    a_edge_from_pin: assert property (@(posedge pclk) disable iff (!presetn) // R14
        rise_seen[0] |-> ($past(second_port_pins[0], 2) && !$past(second_port_pins[0], 3)))
        else $error("edge not from synchronised samples");
    a_irq_off: assert property (@(posedge pclk) disable iff (!presetn) // R02
        !change_irq_master_enable_q |=> !change_irq)
        else $error("change irq while master enable clear");
    a_stat_edge_en: assert property (@(posedge pclk) disable iff (!presetn) // R02
        (any_hit && !change_irq_master_enable_q && !stat_q[pci_pkg::STAT_EDGE_BIT])
        |=> !stat_q[pci_pkg::STAT_EDGE_BIT])
        else $error("edge status set without master enable");
    a_stat_edge_set: assert property (@(posedge pclk) disable iff (!presetn) // R06
        (any_hit && change_irq_master_enable_q) |=> stat_q[pci_pkg::STAT_EDGE_BIT])
        else $error("edge status not set");
    a_summary_read: assert property (@(posedge pclk) disable iff (!presetn) // R07
        (access && !pwrite && paddr == pci_pkg::ADDR_CONTROL)
        |=> (prdata[pci_pkg::CTRL_SUMMARY_BIT] == (|$past(pin_change_flags_q))))
        else $error("summary bit not the or of flags");
    a_wake_cause: assert property (@(posedge pclk) disable iff (!presetn) // R11
        wake_req |-> ($past(sleep_q) && $past(change_irq_master_enable_q)))
        else $error("wake without sleep and master enable");
    a_no_wake_awake: assert property (@(posedge pclk) disable iff (!presetn) // R11
        !sleep_q |=> !wake_req)
        else $error("wake while not sleeping");
    a_sleep_held: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (sleep_q && !any_hit && !wr) |=> sleep_q)
        else $error("sleep left without cause");
    a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error response without ready");

    // ------------------------------------------------------------
    // per-pin checks
    // ------------------------------------------------------------
    generate
        for (g = 0; g < pci_pkg::PIN_COUNT; g++)
        begin : g_pin_chk
            // R05: either edge flags a pin with both enables
            a_both_edges: assert property (@(posedge pclk) disable iff (!presetn) // R05
                ((rise_seen[g] | fall_seen[g]) & rise_edge_enable_q[g] & fall_edge_enable_q[g])
                |=> pin_change_flags_q[g])
                else $error("edge missed with both enables set");
            // R01: a flag moves only by its own edge or a write
            a_pin_isolated: assert property (@(posedge pclk) disable iff (!presetn) // R01
                (!hit[g] && !(wr && paddr == pci_pkg::ADDR_FLAGS))
                |=> (pin_change_flags_q[g] == $past(pin_change_flags_q[g])))
                else $error("pin flag changed without cause");
        end
    endgenerate

endmodule : pci_top
